// ### hw/regulator_enable_sequence_regs.v
`timescale 1ns/1ps
`include "regulator_seq_map.vh"

// What this block does
// - Second linear regulator follows its on bit.
// - With pin gating set, it runs only while on bit and pin high.
// - Discharge path connects while disabled if discharge bit set.
// - First linear level code: 0.8 V plus 100 mV per step, to 0x19.
// - Second linear level code uses the same encoding.
// - First step-down starts after pin rise, 0.5 or 1 ms per count.
// - First step-down stops after pin fall, 0.5 or 1 ms per count.
// - Second step-down starts after pin rise by its own wait.
// - Second step-down stops after pin fall by its own wait.
// - First linear regulator starts after pin rise by its wait.
// - First linear regulator stops after pin fall by its wait.
module regulator_enable_sequence_regs #(
    parameter STEP_CYCLES = `STEP_CYCLES
) (
    // Clock and reset
    input  wire       clk_in,
    input  wire       rstn_in,
    // Register port
    input  wire [7:0] reg_addr_in,
    input  wire [7:0] reg_wdata_in,
    input  wire       reg_write_in,
    output reg  [7:0] reg_rdata_out,
    // Enable pin and scale selects
    input  wire       enable_pin_in,
    input  wire       on_scale_in,
    input  wire       off_scale_in,
    // Rail controls
    output wire       step_down0_on_out,
    output wire       step_down1_on_out,
    output wire       lin_reg0_on_out,
    output wire       lin_reg1_on_out,
    output wire       lin_reg1_discharge_out,
    output reg  [4:0] lin_reg0_level_code_out,
    output reg  [4:0] lin_reg1_level_code_out
);

    reg       rst_sync1_q;
    reg       rst_n_q;
    reg [7:0] lin_reg1_control_q;
    reg [7:0] lin_reg0_level_q;
    reg [7:0] lin_reg1_level_q;
    reg [7:0] step_down0_seq_wait_q;
    reg [7:0] step_down1_seq_wait_q;
    reg [7:0] lin_reg0_seq_wait_q;
    reg       pin_q;
    reg [13:0] prescale_q;
    reg       tick_q;
    reg [7:0] reg_rdata_d;

    wire pin_rise = enable_pin_in & ~pin_q;
    wire pin_fall = ~enable_pin_in & pin_q;

    // Reset release through two flops
    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rst_sync1_q <= 1'b0;
            rst_n_q     <= 1'b0;
        end else begin
            rst_sync1_q <= 1'b1;
            rst_n_q     <= rst_sync1_q;
        end
    end

    function wr_hit;
        input [7:0] addr;
        begin
            wr_hit = reg_write_in && (reg_addr_in == addr);
        end
    endfunction

    // Reserved level codes saturate at the top code
    function [4:0] level_clip;
        input [7:0] level;
        begin
            if (level[`LEVEL_MSB:0] > `LEVEL_MAX_CODE)
                level_clip = `LEVEL_MAX_CODE;
            else
                level_clip = level[`LEVEL_MSB:0];
        end
    endfunction

    // Register file
    always @(posedge clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            lin_reg1_control_q    <= `RST_CONTROL;
            lin_reg0_level_q      <= `RST_LEVEL;
            lin_reg1_level_q      <= `RST_LEVEL;
            step_down0_seq_wait_q <= `RST_WAIT;
            step_down1_seq_wait_q <= `RST_WAIT;
            lin_reg0_seq_wait_q   <= `RST_WAIT;
        end else begin
            // Full byte stored; host keeps reserved bits clear
            if (wr_hit(`ADDR_LIN_REG1_CONTROL))
                lin_reg1_control_q <= reg_wdata_in;
            if (wr_hit(`ADDR_LIN_REG0_LEVEL))
                lin_reg0_level_q <= reg_wdata_in;
            if (wr_hit(`ADDR_LIN_REG1_LEVEL))
                lin_reg1_level_q <= reg_wdata_in;
            if (wr_hit(`ADDR_STEP_DOWN0_WAIT))
                step_down0_seq_wait_q <= reg_wdata_in;
            if (wr_hit(`ADDR_STEP_DOWN1_WAIT))
                step_down1_seq_wait_q <= reg_wdata_in;
            if (wr_hit(`ADDR_LIN_REG0_WAIT))
                lin_reg0_seq_wait_q <= reg_wdata_in;
        end
    end

    // Read mux by address
    always @* begin
        case (reg_addr_in)
            `ADDR_LIN_REG1_CONTROL: reg_rdata_d = lin_reg1_control_q;
            `ADDR_LIN_REG0_LEVEL:   reg_rdata_d = lin_reg0_level_q;
            `ADDR_LIN_REG1_LEVEL:   reg_rdata_d = lin_reg1_level_q;
            `ADDR_STEP_DOWN0_WAIT:  reg_rdata_d = step_down0_seq_wait_q;
            `ADDR_STEP_DOWN1_WAIT:  reg_rdata_d = step_down1_seq_wait_q;
            `ADDR_LIN_REG0_WAIT:    reg_rdata_d = lin_reg0_seq_wait_q;
            default:                reg_rdata_d = 8'h00;
        endcase
    end

    // Read data held in flip-flops, one cycle after the address
    always @(posedge clk_in) begin
        reg_rdata_out <= reg_rdata_d;
    end

    // Level codes forwarded to regulation; reserved codes saturate
    always @(posedge clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            lin_reg0_level_code_out <= 5'h00;
            lin_reg1_level_code_out <= 5'h00;
        end else begin
            lin_reg0_level_code_out <= level_clip(lin_reg0_level_q);
            lin_reg1_level_code_out <= level_clip(lin_reg1_level_q);
        end
    end

    // Enable pin edge detect; reset level matches the idle pin
    always @(posedge clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pin_q <= 1'b0;
        end else begin
            pin_q <= enable_pin_in;
        end
    end

    // Half-millisecond time base
    always @(posedge clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            prescale_q <= 14'h0000;
            tick_q     <= 1'b0;
        end else begin
            if (prescale_q == STEP_CYCLES - 1) begin
                prescale_q <= 14'h0000;
                tick_q     <= 1'b1;
            end else begin
                prescale_q <= prescale_q + 14'h0001;
                tick_q     <= 1'b0;
            end
        end
    end

    // Step-down 0 timing
    rail_sequencer #(.STEP_CYCLES(STEP_CYCLES)) u_step_down0 (
        .clk_in       (clk_in),
        .rst_n_in     (rst_n_q),
        .tick_in      (tick_q),
        .pin_rise_in  (pin_rise),
        .pin_fall_in  (pin_fall),
        .on_wait_in   (step_down0_seq_wait_q[`ON_WAIT_MSB:`ON_WAIT_LSB]),
        .off_wait_in  (step_down0_seq_wait_q[`OFF_WAIT_MSB:`OFF_WAIT_LSB]),
        .on_scale_in  (on_scale_in),
        .off_scale_in (off_scale_in),
        .rail_on_out  (step_down0_on_out)
    );

    // Step-down 1 timing
    rail_sequencer #(.STEP_CYCLES(STEP_CYCLES)) u_step_down1 (
        .clk_in       (clk_in),
        .rst_n_in     (rst_n_q),
        .tick_in      (tick_q),
        .pin_rise_in  (pin_rise),
        .pin_fall_in  (pin_fall),
        .on_wait_in   (step_down1_seq_wait_q[`ON_WAIT_MSB:`ON_WAIT_LSB]),
        .off_wait_in  (step_down1_seq_wait_q[`OFF_WAIT_MSB:`OFF_WAIT_LSB]),
        .on_scale_in  (on_scale_in),
        .off_scale_in (off_scale_in),
        .rail_on_out  (step_down1_on_out)
    );

    // First linear regulator timing
    rail_sequencer #(.STEP_CYCLES(STEP_CYCLES)) u_lin_reg0 (
        .clk_in       (clk_in),
        .rst_n_in     (rst_n_q),
        .tick_in      (tick_q),
        .pin_rise_in  (pin_rise),
        .pin_fall_in  (pin_fall),
        .on_wait_in   (lin_reg0_seq_wait_q[`ON_WAIT_MSB:`ON_WAIT_LSB]),
        .off_wait_in  (lin_reg0_seq_wait_q[`OFF_WAIT_MSB:`OFF_WAIT_LSB]),
        .on_scale_in  (on_scale_in),
        .off_scale_in (off_scale_in),
        .rail_on_out  (lin_reg0_on_out)
    );

    // Second linear regulator enable and discharge
    wire lin_reg1_on_bit    = lin_reg1_control_q[`BIT_ON];
    wire lin_reg1_pin_gate  = lin_reg1_control_q[`BIT_PIN_GATE];
    wire lin_reg1_discharge_on = lin_reg1_control_q[`BIT_DISCHARGE];

    assign lin_reg1_on_out = lin_reg1_on_bit &
                             (~lin_reg1_pin_gate | enable_pin_in);
    assign lin_reg1_discharge_out = ~lin_reg1_on_out &
                                    lin_reg1_discharge_on;

endmodule

// ### inc/regulator_seq_map.vh
`ifndef REGULATOR_SEQ_MAP_VH
`define REGULATOR_SEQ_MAP_VH

// Register addresses
`define ADDR_LIN_REG1_CONTROL 8'h09
`define ADDR_LIN_REG0_LEVEL   8'h0A
`define ADDR_LIN_REG1_LEVEL   8'h0B
`define ADDR_STEP_DOWN0_WAIT  8'h0C
`define ADDR_STEP_DOWN1_WAIT  8'h0D
`define ADDR_LIN_REG0_WAIT    8'h0E

// Field positions
`define BIT_ON                0
`define BIT_PIN_GATE          1
`define BIT_DISCHARGE         2
`define LEVEL_MSB             4
`define CTRL_MSB              2
`define ON_WAIT_MSB           3
`define ON_WAIT_LSB           0
`define OFF_WAIT_MSB          7
`define OFF_WAIT_LSB          4

// Reset values
`define RST_CONTROL           8'h04
`define RST_LEVEL             8'h00
`define RST_WAIT              8'h00

// Level code limits
`define LEVEL_MAX_CODE        5'h19

// Timing: step of 0.5 ms at 20 MHz
`define STEP_TIME_US          500
`define CLK_MHZ               20
`define STEP_CYCLES           (`STEP_TIME_US * `CLK_MHZ)

`endif

// ### hw/rail_sequencer.v
`timescale 1ns/1ps
`include "regulator_seq_map.vh"

module rail_sequencer #(
    parameter STEP_CYCLES = `STEP_CYCLES
) (
    // Clock and reset
    input  wire       clk_in,
    input  wire       rst_n_in,
    // Control
    input  wire       tick_in,
    input  wire       pin_rise_in,
    input  wire       pin_fall_in,
    input  wire [3:0] on_wait_in,
    input  wire [3:0] off_wait_in,
    input  wire       on_scale_in,
    input  wire       off_scale_in,
    // Status
    output reg        rail_on_out
);

    localparam IDLE  = 2'h0;
    localparam UP    = 2'h1;
    localparam DOWN  = 2'h2;

    reg [1:0] state_q;
    reg [4:0] count_q;

    function [4:0] ticks;
        input [3:0] code;
        input       scale;
        begin
            ticks = scale ? {code, 1'b0} : {1'b0, code};
        end
    endfunction

    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_q     <= IDLE;
            count_q     <= 5'h00;
            rail_on_out <= 1'b0;
        end else begin
            // Opposite edge abandons a pending change; wait latched at edge
            if (pin_rise_in) begin
                if (ticks(on_wait_in, on_scale_in) == 5'h00) begin
                    rail_on_out <= 1'b1;
                    state_q     <= IDLE;
                end else begin
                    count_q <= ticks(on_wait_in, on_scale_in);
                    state_q <= UP;
                end
            end else if (pin_fall_in) begin
                if (ticks(off_wait_in, off_scale_in) == 5'h00) begin
                    rail_on_out <= 1'b0;
                    state_q     <= IDLE;
                end else begin
                    count_q <= ticks(off_wait_in, off_scale_in);
                    state_q <= DOWN;
                end
            end else if (tick_in) begin
                case (state_q)
                    UP, DOWN: begin
                        if (count_q == 5'h01) begin
                            rail_on_out <= (state_q == UP);
                            state_q     <= IDLE;
                        end
                        count_q <= count_q - 5'h01;
                    end
                    default: state_q <= IDLE;
                endcase
            end
        end
    end

endmodule

// ### test/regulator_enable_sequence_regs_properties.sv
`timescale 1ns/1ps
`include "regulator_seq_map.vh"
module regulator_seq_checker #(
    parameter STEP_CYCLES = 4
) (
    // Watched ports
    input wire       clk_in,
    input wire       rstn_in,
    input wire [7:0] reg_addr_in,
    input wire [7:0] reg_wdata_in,
    input wire       reg_write_in,
    input wire [7:0] reg_rdata_out,
    input wire       enable_pin_in,
    input wire       step_down0_on_out,
    input wire       step_down1_on_out,
    input wire       lin_reg0_on_out,
    input wire       lin_reg1_on_out,
    input wire       lin_reg1_discharge_out,
    input wire [4:0] lin_reg0_level_code_out,
    input wire [4:0] lin_reg1_level_code_out
);
    localparam int LIM = 30 * STEP_CYCLES + 10;
    logic [7:0] hi_q;
    logic [7:0] lo_q;
    wire  [2:0] rails = {lin_reg0_on_out, step_down1_on_out,
                         step_down0_on_out};
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    // Cycles the pin has held its level
    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            hi_q <= 8'h00;
            lo_q <= 8'h00;
        end else begin
            hi_q <= !enable_pin_in ? 8'h00 : hi_q + 8'(hi_q != LIM);
            lo_q <= enable_pin_in ? 8'h00 : lo_q + 8'(lo_q != LIM);
        end
    end
    sequence s_wr0;
        reg_write_in && reg_addr_in == `ADDR_LIN_REG0_LEVEL
            && reg_wdata_in[4:0] <= `LEVEL_MAX_CODE;
    endsequence
    sequence s_wr1;
        reg_write_in && reg_addr_in == `ADDR_LIN_REG1_LEVEL
            && reg_wdata_in[4:0] <= `LEVEL_MAX_CODE;
    endsequence
    // Read data lags the address by one cycle
    property p_ctl;
        $past(reg_addr_in) == `ADDR_LIN_REG1_CONTROL |->
            $past(lin_reg1_on_out) == (reg_rdata_out[0]
            && (!reg_rdata_out[1] || $past(enable_pin_in)));
    endproperty
    property p_dis;
        $past(reg_addr_in) == `ADDR_LIN_REG1_CONTROL |->
            $past(lin_reg1_discharge_out) ==
            (!$past(lin_reg1_on_out) && reg_rdata_out[2]);
    endproperty
    property p_lvl0;
        s_wr0 |-> ##2 lin_reg0_level_code_out == $past(reg_wdata_in[4:0], 2);
    endproperty
    property p_lvl1;
        s_wr1 |-> ##2 lin_reg1_level_code_out == $past(reg_wdata_in[4:0], 2);
    endproperty
    property p_lim;
        lin_reg0_level_code_out <= 5'h19 && lin_reg1_level_code_out <= 5'h19;
    endproperty
    property p_zero;
        $rose(enable_pin_in) && reg_addr_in == `ADDR_STEP_DOWN0_WAIT
            && reg_rdata_out[3:0] == 4'h0 |-> ##[1:2] step_down0_on_out;
    endproperty
    property p_off;
        lo_q == LIM |-> rails == 3'h0;
    endproperty
    property p_on;
        hi_q == LIM |-> rails == 3'h7;
    endproperty
    property p_abandon;
        lo_q >= 4 |-> !$rose(step_down0_on_out) && !$rose(lin_reg0_on_out);
    endproperty
    a_ctl: assert property (p_ctl) else $error("lin1 enable wrong");
    a_dis: assert property (p_dis) else $error("discharge wrong");
    a_lvl0: assert property (p_lvl0) else $error("level0 wrong");
    a_lvl1: assert property (p_lvl1) else $error("level1 wrong");
    a_lim: assert property (p_lim) else $error("level over max");
    a_zero: assert property (p_zero) else $error("zero wait late");
    a_off: assert property (p_off) else $error("rail not off");
    a_on: assert property (p_on) else $error("rail not on");
    a_abandon: assert property (p_abandon) else $error("rail rose");
endmodule
bind regulator_enable_sequence_regs regulator_seq_checker #(
    .STEP_CYCLES(STEP_CYCLES)
) u_regulator_seq_checker (.*);

// ### test/host_model.sv
`timescale 1ns/1ps
`include "regulator_seq_map.vh"
module host_model (
    // Clock
    input  wire        clk_in,
    // Register port
    output logic [7:0] reg_addr_out,
    output logic [7:0] reg_wdata_out,
    output logic       reg_write_out,
    input  wire  [7:0] reg_rdata_in
);
    initial begin
        reg_addr_out = 8'h00;
        reg_wdata_out = 8'h00;
        reg_write_out = 1'b0;
    end
    task write(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_in);
        reg_addr_out = a;
        reg_wdata_out = (a == `ADDR_LIN_REG1_CONTROL) ? {5'h00, d[2:0]} :
            (a == `ADDR_LIN_REG0_LEVEL || a == `ADDR_LIN_REG1_LEVEL) ?
            {3'h0, d[4:0]} : d;
        reg_write_out = 1'b1;
        @(negedge clk_in);
        reg_write_out = 1'b0;
        reg_wdata_out = ~reg_wdata_out;
    endtask
    task read(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_in);
        reg_addr_out = a;
        @(posedge clk_in);
        #1 d = reg_rdata_in;
    endtask
endmodule

// ### test/regulator_enable_sequence_regs_tb.sv
`timescale 1ns/1ps
module regulator_enable_sequence_regs_tb;
    localparam int SC = 4;
    logic       clk_in = 0, rstn_in = 0, enable_pin_in = 0;
    logic       on_scale_in = 0, off_scale_in = 0;
    wire  [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out;
    wire        reg_write_in, lin_reg1_on_out, lin_reg1_discharge_out;
    wire  [2:0] rails;
    wire  [4:0] lin_reg0_level_code_out, lin_reg1_level_code_out;
    logic [7:0] w[3], d;
    int         fails = 0, checks = 0;
    initial forever #25 clk_in = ~clk_in;
    host_model u_host_model (.clk_in(clk_in), .reg_addr_out(reg_addr_in),
        .reg_wdata_out(reg_wdata_in), .reg_write_out(reg_write_in),
        .reg_rdata_in(reg_rdata_out));
    regulator_enable_sequence_regs #(.STEP_CYCLES(SC))
        u_regulator_enable_sequence_regs (.clk_in(clk_in), .rstn_in(rstn_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_write_in(reg_write_in), .reg_rdata_out(reg_rdata_out),
        .enable_pin_in(enable_pin_in), .on_scale_in(on_scale_in),
        .off_scale_in(off_scale_in), .step_down0_on_out(rails[0]),
        .step_down1_on_out(rails[1]), .lin_reg0_on_out(rails[2]),
        .lin_reg1_on_out(lin_reg1_on_out),
        .lin_reg1_discharge_out(lin_reg1_discharge_out),
        .lin_reg0_level_code_out(lin_reg0_level_code_out),
        .lin_reg1_level_code_out(lin_reg1_level_code_out));
    task results;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input string n, input logic [7:0] s, input logic [7:0] e);
        checks++;
        if (s !== e) begin
            fails++;
            $display("CHECK FAILED %s exp %h got %h", n, e, s);
        end
    endtask
    function int wt(input logic [3:0] k, input logic s);
        return k * (s ? 2 : 1) * SC;
    endfunction
    // Time each rail's change after a pin edge
    task run(input logic lvl);
        int t[3];
        int e;
        logic [3:0] k;
        logic [7:0] ok;
        @(negedge clk_in);
        enable_pin_in = lvl;
        t = '{-1, -1, -1};
        for (int i = 0; i < 30 * SC + 10; i++) begin
            @(negedge clk_in);
            for (int r = 0; r < 3; r++)
                if (rails[r] === lvl && t[r] < 0) t[r] = i;
        end
        for (int r = 0; r < 3; r++) begin
            k = lvl ? w[r][3:0] : w[r][7:4];
            e = wt(k, lvl ? on_scale_in : off_scale_in);
            ok = 8'(t[r] >= e - SC && t[r] <= e + 3);
            chk("delay", ok, 8'h01);
            if (t[r] < 0) begin
                fails++;
                results();
            end
        end
    endtask
    initial begin
        void'($urandom(12864));
        repeat (6) @(posedge clk_in);
        @(negedge clk_in) rstn_in = 1;
        repeat (3) @(negedge clk_in);
        for (int a = 8; a < 16; a++) begin
            u_host_model.read(8'(a), d);
            chk("reset/unmapped", d, a == 9 ? 8'h04 : 8'h00);
        end
        for (int i = 0; i < 6; i++) begin
            d = i < 2 ? 8'(i * 25) : 8'($urandom_range(0, 25));
            u_host_model.write(8'h0A, d);
            u_host_model.write(8'h0B, 8'h19 - d);
            u_host_model.read(8'h0A, w[0]);
            chk("level reg", w[0], d);
            chk("level0", 8'(lin_reg0_level_code_out), d);
            chk("level1", 8'(lin_reg1_level_code_out), 8'h19 - d);
        end
        for (int i = 0; i < 16; i++) begin
            u_host_model.write(8'h09, 8'(i));
            enable_pin_in = i[3];
            d = 8'(i[0] && (!i[1] || i[3]));
            @(posedge clk_in);
            #1 chk("lin1 on", 8'(lin_reg1_on_out), d);
            d = 8'(!d[0] && i[2]);
            chk("discharge", 8'(lin_reg1_discharge_out), d);
        end
        enable_pin_in = 0;
        repeat (30 * SC + 10) @(negedge clk_in);
        for (int j = 0; j < 5; j++) begin
            for (int r = 2; r >= 0; r--) begin
                w[r] = j == 0 ? 8'h00 : j == 1 ? 8'hFF : 8'($urandom);
                u_host_model.write(8'(8'h0C + r), w[r]);
            end
            on_scale_in = j == 1 ? 1'b1 : 1'($urandom);
            off_scale_in = j == 1 ? 1'b1 : 1'($urandom);
            run(1);
            run(0);
        end
        for (int r = 0; r < 3; r++) begin
            w[r] = 8'h0F;
            u_host_model.write(8'(8'h0C + r), w[r]);
        end
        run(1);
        run(0);
        enable_pin_in = 1;
        repeat (2 * SC) @(negedge clk_in);
        enable_pin_in = 0;
        d = 8'h00;
        repeat (30 * SC + 10) @(negedge clk_in) d = d | 8'(rails);
        chk("abandoned start", d, 8'h00);
        results();
    end
endmodule
